// ### common/alsr_pkg.sv
package alsr_pkg;

  // instruction word width and accumulator width
  localparam int          INSN_W      = 10;
  localparam int          ACC_W       = 4;
  localparam int          SP_W        = 3;

  // opcodes of the four transfer instructions
  localparam logic [9:0]  OP_LOAD_SP  = 10'h050;
  localparam logic [9:0]  OP_LOAD_V1  = 10'h054;
  localparam logic [9:0]  OP_LOAD_V2  = 10'h055;
  localparam logic [9:0]  OP_LOAD_W1  = 10'h24B;

  // reset value of the accumulator copy held here
  localparam logic [3:0]  ACC_RST     = 4'h0;

  // reset value of every single-bit flag output
  localparam logic        FLAG_RST    = 1'b0;

  // cycles per instruction
  localparam int          INSN_CYCLES = 1;

  // decoded operation, one-hot
  typedef enum logic [4:0] {
    ALSR_OP_NONE = 5'h01,
    ALSR_OP_SP   = 5'h02,
    ALSR_OP_V1   = 5'h04,
    ALSR_OP_V2   = 5'h08,
    ALSR_OP_W1   = 5'h10
  } alsr_op_t;

endpackage : alsr_pkg

// ### dv/alsr_properties.sv
`timescale 1ns/1ps
module alsr_properties
(
  input       CORE_CLK_I, SRST_I, INSN_VALID_I, ACC_WE_O, CARRY_WE_O,
  input       SKIP_O, SP_WE_O, CTRL_RD_STROBE_O,
  input [9:0] INSN_I,
  input [2:0] STACK_POINTER_I,
  input [3:0] INT_CTRL_REG_1_I, INT_CTRL_REG_2_I, TIMER_CTRL_REG_1_I,
  input [3:0] ACC_DATA_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  // an accepted word, then the write one edge later
  sequence s_word(op);
    INSN_VALID_I && INSN_I == op;
  endsequence
  sequence s_write(d);
    ACC_WE_O && ACC_DATA_O == $past(d);
  endsequence
  property p_ld(op, d);
    s_word(op) |=> s_write(d);
  endproperty
  a_sp_low: assert property (p_ld(10'h050,
    {1'b0, STACK_POINTER_I})) else $error("sp");
  a_sp_top: assert property (s_word(10'h050) |=> !ACC_DATA_O[3])
    else $error("a3");
  a_int_one: assert property (p_ld(10'h054,
    INT_CTRL_REG_1_I)) else $error("v1");
  a_int_two: assert property (p_ld(10'h055,
    INT_CTRL_REG_2_I)) else $error("v2");
  a_tmr_one: assert property (p_ld(10'h24B,
    TIMER_CTRL_REG_1_I)) else $error("w1");
  a_no_side: assert property (!(CARRY_WE_O | SKIP_O | SP_WE_O))
    else $error("side");
  a_no_strobe: assert property (!CTRL_RD_STROBE_O)
    else $error("rd");
endmodule : alsr_properties

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic CORE_CLK_I = 1'b0, SRST_I = 1'b1, INSN_VALID_I, ACC_WE_O, SKIP_O;
  logic CARRY_WE_O, SP_WE_O, CTRL_RD_STROBE_O;
  logic [9:0] INSN_I;
  logic [2:0] STACK_POINTER_I;
  logic [3:0] INT_CTRL_REG_1_I, INT_CTRL_REG_2_I, TIMER_CTRL_REG_1_I;
  logic [3:0] ACC_DATA_O;
  logic [4:0] e_acc = 5'h00;
  logic [25:0] s = 26'h0;
  int failures = 0, n_checks = 0;
  integer seed = 32'hC9019207;
  logic [3:0] k;
  // one word feeds every input but clock and reset, so none floats
  assign {INSN_VALID_I, INSN_I, STACK_POINTER_I, INT_CTRL_REG_1_I,
    INT_CTRL_REG_2_I, TIMER_CTRL_REG_1_I} = s;
  always #5 CORE_CLK_I = ~CORE_CLK_I;
  alsr_acc_load i_dut (.*);
  // expected write flag and value for a stimulus word
  function automatic logic [4:0] acc_of(input logic [25:0] w);
    case (w[25:15])
      11'h450: return {2'h2, w[14:12]};
      11'h454: return {1'b1, w[11:8]};
      11'h455: return {1'b1, w[7:4]};
      11'h64B: return {1'b1, w[3:0]};
      default: return 5'h00;
    endcase
  endfunction : acc_of
  task chk(input logic [4:0] got, exp);
    n_checks++;
    failures += int'(got !== exp);
    if (got !== exp) $display("[ERR] %0t acc %h not %h", $time, got, exp);
  endtask : chk
  task chk_side(input logic [3:0] got);
    n_checks++;
    failures += int'(got !== 4'h0);
    if (got !== 4'h0) $display("[ERR] %0t side %h not 0", $time, got);
  endtask : chk_side
  task wrap_up;
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // the run needs some 5200 ns
  initial #20000 begin failures++; wrap_up(); end
  initial
  begin
    repeat (16) @(negedge CORE_CLK_I);
    SRST_I = 1'b0;
    for (int i = 0; i < 500; i++)
    begin
      @(negedge CORE_CLK_I);
      chk({ACC_WE_O, ACC_DATA_O}, e_acc);
      chk_side({CARRY_WE_O, SKIP_O, SP_WE_O, 1'b0});
      chk_side({3'h0, CTRL_RD_STROBE_O});
      s = 26'($random(seed));
      k = 4'($random(seed));
      // steer half the words to the four opcodes or the near miss 051
      if (k[0]) s[24:15] = k[1] ? 10'h24B : {7'h0A, k[2], 1'b0, k[3]};
      // all-ones sources: bit 3 must still clear on the stack load
      if (i == 3) s = 26'h2287FFF;
      // a reset in mid-run must clear the outputs
      SRST_I = (i >= 200 && i < 203);
      e_acc = SRST_I ? 5'h00 : acc_of(s);
    end
    @(negedge CORE_CLK_I);
    chk({ACC_WE_O, ACC_DATA_O}, e_acc);
    wrap_up();
  end
endmodule : testbench
bind alsr_acc_load alsr_properties i_props (.*);

// ### rtl/alsr_acc_load.sv
// Function
// - stack pointer bits copied to acc 2..0
// - acc bit 3 cleared on stack load
// - stack, carry untouched; never skip next
// - interrupt control 1 copied whole to acc
// - opcode 055 copies interrupt control 2
// - opcode 24B copies timer control 1
`timescale 1ns/1ps

module alsr_acc_load
(
  // clock and reset
  input  wire logic                         CORE_CLK_I,
  input  wire logic                         SRST_I,
  // instruction from the decoder, valid per instruction cycle
  input  wire logic                         INSN_VALID_I,
  input  wire logic [alsr_pkg::INSN_W-1:0]  INSN_I,
  // special register values, read only here
  input  wire logic [alsr_pkg::SP_W-1:0]    STACK_POINTER_I,
  input  wire logic [alsr_pkg::ACC_W-1:0]   INT_CTRL_REG_1_I,
  input  wire logic [alsr_pkg::ACC_W-1:0]   INT_CTRL_REG_2_I,
  input  wire logic [alsr_pkg::ACC_W-1:0]   TIMER_CTRL_REG_1_I,
  // accumulator write port
  output logic                              ACC_WE_O,
  output logic      [alsr_pkg::ACC_W-1:0]   ACC_DATA_O,
  // side-effect controls, always inactive for these instructions
  output logic                              CARRY_WE_O,
  output logic                              SKIP_O,
  output logic                              SP_WE_O,
  output logic                              CTRL_RD_STROBE_O
);

  import alsr_pkg::*;

  // decoded operation and the value it loads
  alsr_op_t          op_nxt;
  logic [ACC_W-1:0]  acc_nxt;
  // one match flag per opcode
  logic              hit_sp;
  logic              hit_v1;
  logic              hit_v2;
  logic              hit_w1;

  // one comparator per opcode; at most one hit is high
  // stack load match
  alsr_op_match
  #(
    .OPCODE  (OP_LOAD_SP)
  )
  i_match_sp
  (
    .valid_i (INSN_VALID_I),
    .insn_i  (INSN_I),
    .hit_o   (hit_sp)
  );

  alsr_op_match
  #(
    .OPCODE  (OP_LOAD_V1)
  )
  i_match_v1
  (
    .valid_i (INSN_VALID_I),
    .insn_i  (INSN_I),
    .hit_o   (hit_v1)
  );

  alsr_op_match
  #(
    .OPCODE  (OP_LOAD_V2)
  )
  i_match_v2
  (
    .valid_i (INSN_VALID_I),
    .insn_i  (INSN_I),
    .hit_o   (hit_v2)
  );

  alsr_op_match
  #(
    .OPCODE  (OP_LOAD_W1)
  )
  i_match_w1
  (
    .valid_i (INSN_VALID_I),
    .insn_i  (INSN_I),
    .hit_o   (hit_w1)
  );

  // a word that matches none loads nothing; other units own it
  always_comb
  begin
    op_nxt = ALSR_OP_NONE;
    case ({hit_sp, hit_v1, hit_v2, hit_w1})
      4'h8:    op_nxt = ALSR_OP_SP;
      4'h4:    op_nxt = ALSR_OP_V1;
      4'h2:    op_nxt = ALSR_OP_V2;
      4'h1:    op_nxt = ALSR_OP_W1;
      default: op_nxt = ALSR_OP_NONE;
    endcase
  end

  // select the source value for the accumulator
  always_comb
  begin
    acc_nxt = ACC_RST;
    case (op_nxt)
      ALSR_OP_SP: acc_nxt = {1'b0, STACK_POINTER_I};
      ALSR_OP_V1: acc_nxt = INT_CTRL_REG_1_I;
      ALSR_OP_V2: acc_nxt = INT_CTRL_REG_2_I;
      ALSR_OP_W1: acc_nxt = TIMER_CTRL_REG_1_I;
      default:    acc_nxt = ACC_RST;
    endcase
  end

  // write strobe, one cycle per instruction
  // one-cycle accumulator write
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      ACC_WE_O <= FLAG_RST;
    end
    else
    begin
      ACC_WE_O <= (op_nxt != ALSR_OP_NONE);
    end
  end

  // data is zero when idle, so a stray strobe shows
  // selected source registered
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      ACC_DATA_O <= ACC_RST;
    end
    else
    begin
      ACC_DATA_O <= acc_nxt;
    end
  end

  // carry write held off, these loads are pure moves
  // carry left alone
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      CARRY_WE_O <= FLAG_RST;
    end
    else
    begin
      CARRY_WE_O <= 1'b0;
    end
  end

  // skip request held off for every load here
  // never skip next
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      SKIP_O <= FLAG_RST;
    end
    else
    begin
      SKIP_O <= 1'b0;
    end
  end

  // stack is only read; a write here would corrupt returns
  // stack pointer untouched
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      SP_WE_O <= FLAG_RST;
    end
    else
    begin
      SP_WE_O <= 1'b0;
    end
  end

  // no read strobe, so flags in peripherals never clear
  // no peripheral side effect
  always_ff @(posedge CORE_CLK_I)
  begin
    if (SRST_I)
    begin
      CTRL_RD_STROBE_O <= FLAG_RST;
    end
    else
    begin
      CTRL_RD_STROBE_O <= 1'b0;
    end
  end

endmodule : alsr_acc_load

// one opcode comparator, reused for each transfer
module alsr_op_match
#(
  parameter logic [alsr_pkg::INSN_W-1:0] OPCODE = 10'h000
)
(
  // instruction word and its qualifier
  input  wire logic                         valid_i,
  input  wire logic [alsr_pkg::INSN_W-1:0]  insn_i,
  // high when the word is this opcode
  output logic                              hit_o
);

  import alsr_pkg::*;

  // valid gates the compare so an idle word never matches
  assign hit_o = valid_i && (insn_i == OPCODE);

endmodule : alsr_op_match
